// [rtl/sct_handler.sv]
// How it works
// - Header top bits: 0b100 marks module responses, 0b101 host commands.
// - Host waits for the answer; module answers within 5 ms.
// - Confirmation: two sync bytes, 0x8B, 0x58, nine zero bytes, checksum.
// - Failed operation of a host command is answered with the general error.
// - Set-base command: 0xAB, 0x18, four base bytes MSB first, zeros, checksum.
// - Valid set-base stores upper 25 bits; low seven bits read as zero.
// - Base outside 0xFF80_0000..0xFFFF_FFFE gets range error, no reprogramming.
// - At most ten reprogrammings; further attempts get the general error.
// - Successful reprogramming is answered with the confirmation.
// - Read-base answers 0x8B, 0x98 and the four base bytes MSB first.
// - Set-sensitivity opcode 0x08, first data byte 0x00 low, 0x01 high.
// - Low sensitivity keeps the receiver to nearby transmitters only.
// - A sensitivity change is confirmed with the confirmation telegram.
// - Read-sensitivity answers 0x8B, 0x88 with current value in first byte.
// - Reset command 0x0A resets the controller and sends no answer.
// - Read-version answers 0x8C: four firmware then four interface bytes.
// - Malformed command yields syntax error naming type, length, checksum, origin.
// - Radio telegram with foreign identifier: transmit-range error, not sent.
// - Identifier-range error is 0x8B, 0x1A, nine zero bytes, checksum.
`default_nettype none
module sct_handler #(
  parameter int unsigned RESP_CYCLES = int'(sct_pkg::RESP_TIME_NS / sct_pkg::CLK_PERIOD_NS),
  parameter logic [24:0] BASE_RESET  = 25'h1ff_0000,           // Arbitrary in-range value
  parameter logic [31:0] UNIQUE_ID   = 32'h0123_4567,          // Arbitrary value
  parameter logic [63:0] VERSION     = 64'h0100_0110_0100_0102 // Arbitrary value
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // Received bytes from the serial framer
  input  wire logic         rx_valid,
  input  wire logic [7:0]   rx_byte,
  // Bytes to the serial framer
  output logic              tx_valid,
  output logic [7:0]        tx_byte,
  input  wire logic         tx_ready,
  // Radio side
  output logic              rx_sens_high,
  output logic              radio_tx_go,
  output logic [87:0]       radio_tx_tel,
  // Controller and non-volatile store
  output logic              mcu_reset_req,
  output logic              nv_base_wr,
  output logic [24:0]       nv_base,
  output logic              resp_late
);

  localparam int WCW = $clog2(RESP_CYCLES + 1);
  localparam logic [WCW-1:0] WAIT_LIMIT = WCW'(RESP_CYCLES);
  localparam logic [WCW-1:0] WAIT_LAST  = WCW'(RESP_CYCLES - 1);

  typedef struct packed {
    sct_pkg::sct_state_t      state;
    logic [3:0]               idx;
    logic [10:0][7:0]         tel;       // Bytes 2..12, received or to send
    logic [7:0]               sum;
    logic                     chk_bad;
    logic [24:0]              base;
    logic [3:0]               rewrites;
    logic                     sens_high;
    logic                     tx_valid;
    logic [7:0]               tx_byte;
    logic                     mcu_reset;
    logic                     radio_go;
    logic [87:0]              radio_tel;
    logic                     nv_write;
    logic                     late;
    logic [WCW-1:0]           wait_cnt;
  } sct_regs_t;

  sct_regs_t st_ff;
  sct_regs_t nxt_st;

  // Fields of the received telegram
  logic [2:0]  rx_type;
  logic [4:0]  rx_len;
  logic [7:0]  rx_op;
  logic [31:0] rx_base;
  logic [31:0] rx_radio_id;
  logic        base_ok;
  logic        radio_id_ok;
  logic [31:0] cur_base;

  assign rx_type     = st_ff.tel[0][7:5];
  assign rx_len      = st_ff.tel[0][4:0];
  assign rx_op       = st_ff.tel[1];
  assign rx_base     = {st_ff.tel[2], st_ff.tel[3], st_ff.tel[4], st_ff.tel[5]};
  assign rx_radio_id = {st_ff.tel[6], st_ff.tel[7], st_ff.tel[8], st_ff.tel[9]};
  assign cur_base    = {st_ff.base, {sct_pkg::BASE_LSB_W{1'b0}}};
  // Inclusive window; all-ones stays excluded as broadcast
  assign base_ok     = (rx_base >= sct_pkg::BASE_MIN) &&
                       (rx_base <= sct_pkg::BASE_MAX);
  // Own unique identifier or one of the 128 above the base
  assign radio_id_ok = (rx_radio_id == UNIQUE_ID) ||
                       (rx_radio_id[31:sct_pkg::BASE_LSB_W] == st_ff.base);

  // Next-state logic
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.mcu_reset = 1'b0;
    nxt_st.radio_go  = 1'b0;
    nxt_st.nv_write  = 1'b0;
    nxt_st.late      = 1'b0;
    case (st_ff.state)
      sct_pkg::ST_HUNT: begin
        if (rx_valid && rx_byte == sct_pkg::SYNC_FIRST) begin
          nxt_st.state = sct_pkg::ST_SYNC2;
        end
      end
      sct_pkg::ST_SYNC2: begin
        if (rx_valid) begin
          if (rx_byte == sct_pkg::SYNC_SECOND) begin
            nxt_st.state = sct_pkg::ST_BODY;
            nxt_st.idx   = sct_pkg::IDX_BODY;
            nxt_st.sum   = 8'h00;
          end else if (rx_byte != sct_pkg::SYNC_FIRST) begin
            nxt_st.state = sct_pkg::ST_HUNT;
          end
        end
      end
      sct_pkg::ST_BODY: begin
        if (rx_valid) begin
          if (st_ff.idx == sct_pkg::IDX_LAST) begin
            nxt_st.chk_bad = (rx_byte != st_ff.sum);
            nxt_st.state   = sct_pkg::ST_EXEC;
          end else begin
            nxt_st.tel[st_ff.idx - sct_pkg::IDX_BODY] = rx_byte;
            nxt_st.sum = st_ff.sum + rx_byte;
            nxt_st.idx = st_ff.idx + 4'h1;
          end
        end
      end
      sct_pkg::ST_EXEC: begin
        // Answer is built in place; unused bytes stay zero
        nxt_st.tel      = '0;
        nxt_st.tel[0]   = sct_pkg::HDR_RESPONSE;
        nxt_st.tel[1]   = sct_pkg::OP_OK;
        nxt_st.state    = sct_pkg::ST_SEND;
        nxt_st.idx      = 4'h0;
        nxt_st.sum      = 8'h00;
        nxt_st.wait_cnt = '0;
        // Checksum first, then type, length, origin
        if (st_ff.chk_bad) begin
          nxt_st.tel[1] = sct_pkg::FIELD_SUM;
        end else if (rx_type != sct_pkg::TYPE_COMMAND && rx_type != sct_pkg::TYPE_RADIO_TX) begin
          nxt_st.tel[1] = sct_pkg::FIELD_TYPE;
        end else if (rx_len != sct_pkg::LEN_FIELD) begin
          nxt_st.tel[1] = sct_pkg::FIELD_LEN;
        end else if (rx_type == sct_pkg::TYPE_RADIO_TX) begin
          if (radio_id_ok) begin
            nxt_st.radio_go  = 1'b1;
            nxt_st.radio_tel = st_ff.tel;
          end else begin
            nxt_st.tel[1] = sct_pkg::OP_ERR_TXRNG;
          end
        end else begin
          case (rx_op)
            sct_pkg::OP_SET_BASE: begin
              // Limit check first: a spent counter refuses every value
              if (st_ff.rewrites >= sct_pkg::MAX_REWRITES) begin
                nxt_st.tel[1] = sct_pkg::OP_ERR;
              end else if (!base_ok) begin
                nxt_st.tel[1] = sct_pkg::OP_ERR_RANGE;
              end else begin
                nxt_st.base     = rx_base[31:sct_pkg::BASE_LSB_W];
                nxt_st.rewrites = st_ff.rewrites + 4'h1;
                nxt_st.nv_write = 1'b1;
                nxt_st.tel[1]   = sct_pkg::OP_OK;
              end
            end
            sct_pkg::OP_RD_BASE: begin
              nxt_st.tel[1] = sct_pkg::OP_INF_BASE;
              nxt_st.tel[2] = cur_base[31:24];
              nxt_st.tel[3] = cur_base[23:16];
              nxt_st.tel[4] = cur_base[15:8];
              nxt_st.tel[5] = cur_base[7:0];
            end
            sct_pkg::OP_SET_SENS: begin
              if (st_ff.tel[2] == sct_pkg::SENS_LOW) begin
                nxt_st.sens_high = 1'b0;
              end else if (st_ff.tel[2] == sct_pkg::SENS_HIGH) begin
                nxt_st.sens_high = 1'b1;
              end else begin
                nxt_st.tel[1] = sct_pkg::OP_ERR;
              end
            end
            sct_pkg::OP_RD_SENS: begin
              nxt_st.tel[1] = sct_pkg::OP_INF_SENS;
              nxt_st.tel[2] = st_ff.sens_high ? sct_pkg::SENS_HIGH : sct_pkg::SENS_LOW;
            end
            sct_pkg::OP_RESET: begin
              nxt_st.mcu_reset = 1'b1;
              nxt_st.state     = sct_pkg::ST_HUNT;
            end
            sct_pkg::OP_RD_VER: begin
              nxt_st.tel[1] = sct_pkg::OP_INF_VER;
              for (int i = 0; i < 8; i++) begin
                nxt_st.tel[2 + i] = VERSION[63 - 8 * i -: 8];
              end
            end
            default: begin
              nxt_st.tel[1] = sct_pkg::FIELD_ORG;
            end
          endcase
        end
      end
      sct_pkg::ST_SEND: begin
        // Deadline watch until the first byte leaves
        if (st_ff.idx == 4'h0 && st_ff.wait_cnt != WAIT_LIMIT) begin
          nxt_st.wait_cnt = st_ff.wait_cnt + WCW'(1);
          nxt_st.late     = (st_ff.wait_cnt == WAIT_LAST);
        end
        if (!st_ff.tx_valid) begin
          nxt_st.tx_valid = 1'b1;
          if (st_ff.idx == 4'h0) begin
            nxt_st.tx_byte = sct_pkg::SYNC_FIRST;
          end else if (st_ff.idx == 4'h1) begin
            nxt_st.tx_byte = sct_pkg::SYNC_SECOND;
          end else if (st_ff.idx == sct_pkg::IDX_LAST) begin
            nxt_st.tx_byte = st_ff.sum;
          end else begin
            nxt_st.tx_byte = st_ff.tel[st_ff.idx - sct_pkg::IDX_BODY];
            nxt_st.sum     = st_ff.sum + st_ff.tel[st_ff.idx - sct_pkg::IDX_BODY];
          end
        end else if (tx_ready) begin
          nxt_st.tx_valid = 1'b0;
          nxt_st.idx      = st_ff.idx + 4'h1;
          // Commands arriving during the answer are dropped by design
          if (st_ff.idx == sct_pkg::IDX_LAST) begin
            nxt_st.state = sct_pkg::ST_HUNT;
          end
        end
      end
      default: begin
        nxt_st.state = sct_pkg::ST_HUNT;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff           <= '0;
      st_ff.state     <= sct_pkg::ST_HUNT;
      st_ff.base      <= BASE_RESET;
      st_ff.sens_high <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign tx_valid      = st_ff.tx_valid;
  assign tx_byte       = st_ff.tx_byte;
  assign rx_sens_high  = st_ff.sens_high;  // Low keeps the radio to near senders
  assign radio_tx_go   = st_ff.radio_go;
  assign radio_tx_tel  = st_ff.radio_tel;
  assign mcu_reset_req = st_ff.mcu_reset;
  assign nv_base_wr    = st_ff.nv_write;
  assign nv_base       = st_ff.base;
  assign resp_late     = st_ff.late;

endmodule
`default_nettype wire

// [rtl/sct_pkg.sv]
`default_nettype none
package sct_pkg;

  // Telegram framing
  localparam logic [7:0] SYNC_FIRST   = 8'ha5;
  localparam logic [7:0] SYNC_SECOND  = 8'h5a;
  localparam logic [3:0] IDX_BODY     = 4'h2;  // First byte after sync
  localparam logic [3:0] IDX_LAST     = 4'hd;  // Checksum byte index
  localparam int         BODY_BYTES   = 11;    // Bytes 2..12

  // Header byte: telegram_type_code in [7:5], length in [4:0]
  localparam logic [2:0] TYPE_RESPONSE = 3'h4;  // module_response_telegram
  localparam logic [2:0] TYPE_COMMAND  = 3'h5;  // host_command_telegram
  localparam logic [2:0] TYPE_RADIO_TX = 3'h3;  // Radio telegram to transmit
  localparam logic [4:0] LEN_FIELD     = 5'h0b;
  localparam logic [7:0] HDR_RESPONSE  = 8'h8b;

  // Host command opcodes
  localparam logic [7:0] OP_SET_BASE   = 8'h18;
  localparam logic [7:0] OP_RD_BASE    = 8'h58;
  localparam logic [7:0] OP_SET_SENS   = 8'h08;
  localparam logic [7:0] OP_RD_SENS    = 8'h48;
  localparam logic [7:0] OP_RESET      = 8'h0a;
  localparam logic [7:0] OP_RD_VER     = 8'h4b;

  // Response opcodes
  localparam logic [7:0] OP_OK         = 8'h58;
  localparam logic [7:0] OP_ERR        = 8'h19;
  localparam logic [7:0] OP_INF_BASE   = 8'h98;
  localparam logic [7:0] OP_INF_SENS   = 8'h88;
  localparam logic [7:0] OP_INF_VER    = 8'h8c;
  localparam logic [7:0] OP_ERR_TXRNG  = 8'h22;
  localparam logic [7:0] OP_ERR_RANGE  = 8'h1a;

  // Syntax error field codes
  localparam logic [7:0] FIELD_TYPE    = 8'h08;
  localparam logic [7:0] FIELD_LEN     = 8'h09;
  localparam logic [7:0] FIELD_SUM     = 8'h0a;
  localparam logic [7:0] FIELD_ORG     = 8'h0b;

  // Sensitivity encoding
  localparam logic [7:0] SENS_LOW      = 8'h00;
  localparam logic [7:0] SENS_HIGH     = 8'h01;

  // Base identifier range and storage
  localparam logic [31:0] BASE_MIN     = 32'hff80_0000;
  localparam logic [31:0] BASE_MAX     = 32'hffff_fffe;
  localparam int          BASE_LSB_W   = 7;
  localparam int          BASE_MSB_W   = 25;
  localparam logic [3:0]  MAX_REWRITES = 4'ha;

  // Response deadline
  localparam longint RESP_TIME_NS  = 5000000;
  localparam longint CLK_PERIOD_NS = 10;

  typedef enum logic [2:0] {
    ST_HUNT  = 3'b000,
    ST_SYNC2 = 3'b001,
    ST_BODY  = 3'b011,
    ST_EXEC  = 3'b010,
    ST_SEND  = 3'b110
  } sct_state_t;

endpackage
`default_nettype wire

// [testbench/sct_handler_checker.sv]
`default_nettype none
module sct_handler_checker #(
  parameter logic [31:0] UNIQUE_ID = 32'h0
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // Byte stream toward the host
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_ready,
  // Side effects
  input wire logic        rx_sens_high,
  input wire logic        radio_tx_go,
  input wire logic [87:0] radio_tx_tel,
  input wire logic        mcu_reset_req,
  input wire logic        nv_base_wr,
  input wire logic [24:0] nv_base
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Id of an accepted radio telegram, byte 8 most significant
  logic [31:0] tx_id;
  assign tx_id = {radio_tx_tel[55:48], radio_tx_tel[63:56], radio_tx_tel[71:64],
                  radio_tx_tel[79:72]};

  chk_byte_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("answer byte changed before taken");
  chk_byte_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
    else $error("no idle cycle after taken byte");
  chk_nv_pulse: assert property (nv_base_wr |=> !nv_base_wr)
    else $error("store strobe longer than one cycle");
  chk_nv_range: assert property (nv_base_wr |-> nv_base >= 25'h1ff_0000)
    else $error("stored base below allowed range");
  chk_base_hold: assert property (
    $changed(nv_base) |-> nv_base_wr || $past(nv_base_wr))
    else $error("base changed without store");
  chk_go_id: assert property (
    radio_tx_go |-> tx_id == UNIQUE_ID || tx_id[31:7] == nv_base)
    else $error("radio telegram sent with foreign id");
  chk_go_kind: assert property (
    radio_tx_go |-> radio_tx_tel[7:5] == 3'h3 ##1 !radio_tx_go)
    else $error("bad radio launch");
  chk_reset_quiet: assert property (
    mcu_reset_req |=> (!tx_valid && !mcu_reset_req) [*8])
    else $error("answer after reset command");
  chk_sens_ack: assert property ($changed(rx_sens_high) |-> ##[0:4] tx_valid)
    else $error("sensitivity change not answered");

  cover property (nv_base_wr);
  cover property (radio_tx_go);
  cover property (mcu_reset_req);
endmodule

bind sct_handler sct_handler_checker #(.UNIQUE_ID(UNIQUE_ID)) chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .tx_valid(tx_valid), .tx_byte(tx_byte),
  .tx_ready(tx_ready), .rx_sens_high(rx_sens_high), .radio_tx_go(radio_tx_go),
  .radio_tx_tel(radio_tx_tel), .mcu_reset_req(mcu_reset_req), .nv_base_wr(nv_base_wr),
  .nv_base(nv_base)
);
`default_nettype wire

// [testbench/sct_handler_tb_top.sv]
`default_nettype none
module sct_handler_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] VER = 64'h0100_0110_0100_0102; // Arbitrary value
  localparam logic [31:0] UID = 32'h0123_4567;           // Arbitrary value
  localparam logic [7:0]  CMD = 8'hab;
  logic        sys_clk;
  logic        rst_b;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        tx_valid;
  logic [7:0]  tx_byte;
  logic        tx_ready;
  logic        rx_sens_high;
  logic        radio_tx_go;
  logic [87:0] radio_tx_tel;
  logic        mcu_reset_req;
  logic        nv_base_wr;
  logic [24:0] nv_base;
  logic        resp_late;
  int          errors = 0;
  int          checks = 0;
  int          gos    = 0;
  int          resets = 0;
  int          lates  = 0;

  sct_handler #(.RESP_CYCLES(50), .BASE_RESET(25'h1ff_0001), .UNIQUE_ID(UID), .VERSION(VER)) uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .rx_sens_high(rx_sens_high),
    .radio_tx_go(radio_tx_go), .radio_tx_tel(radio_tx_tel), .mcu_reset_req(mcu_reset_req),
    .nv_base_wr(nv_base_wr), .nv_base(nv_base), .resp_late(resp_late));
  sct_host host (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Pulse counters
  always @(posedge sys_clk) begin
    gos <= gos + int'(radio_tx_go);
    resets <= resets + int'(mcu_reset_req);
    lates <= lates + int'(resp_late);
  end

  task automatic cmp(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for all 14 bytes, then judge each
  task automatic answer(input logic [7:0] op, input logic [71:0] d);
    logic [7:0] sum;
    sum = 8'h8b + op;
    for (int k = 0; k < 2000 && host.n < 14; k++) begin
      @(posedge sys_clk);
    end
    @(negedge sys_clk);
    cmp(host.n, 14);
    cmp({host.resp[0], host.resp[1]}, 16'ha55a);
    cmp(host.resp[2], 8'h8b);
    cmp(host.resp[3], op);
    for (int i = 0; i < 9; i++) begin
      sum = sum + d[71-8*i -: 8];
      cmp(host.resp[4+i], d[71-8*i -: 8]);
    end
    cmp(host.resp[13], sum);
  endtask

  task automatic run(input logic [7:0] hdr, op, input logic [71:0] d,
                     input logic [7:0] bad, rop, input logic [71:0] rd);
    host.send(hdr, op, d, bad);
    answer(rop, rd);
  endtask

  // Low, high, then an illegal code that must not stick
  task automatic t_sens();
    for (int s = 0; s < 3; s++) begin
      run(CMD, 8'h08, {8'(s), 64'h0}, 0,
          s < 2 ? 8'h58 : sct_pkg::OP_ERR, 0);
      cmp(rx_sens_high, s > 0);
      run(CMD, 8'h48, 0, 0, 8'h88, {8'(s > 0), 64'h0});
    end
  endtask

  // Range edges, ten rewrites, the eleventh refused
  task automatic t_base();
    logic [31:0] v;
    run(CMD, 8'h58, 0, 0, 8'h98, {32'hff80_0080, 40'h0});
    run(CMD, 8'h18, {32'hff7f_ffff, 40'h0}, 0, 8'h1a, 0);
    run(CMD, 8'h18, {32'hffff_ffff, 40'h0}, 0, 8'h1a, 0);
    cmp(nv_base, 25'h1ff_0001);
    for (int i = 0; i < 10; i++) begin
      v = 32'hffff_fffe - 32'(i * 128);
      run(CMD, 8'h18, {v, 40'h0}, 0, 8'h58, 0);
      cmp(nv_base, v[31:7]);
    end
    run(CMD, 8'h18, {32'hff80_0000, 40'h0}, 0, sct_pkg::OP_ERR, 0);
    run(CMD, 8'h58, 0, 0, 8'h98, {v[31:7], 7'h0, 40'h0});
  endtask

  // One malformed command per faulty field
  task automatic t_syntax();
    logic [31:0] hdrs;
    logic [31:0] ops;
    logic [31:0] flds;
    hdrs = {CMD, 8'hcb, 8'haa, CMD};
    ops = {8'h48, 8'h48, 8'h48, 8'h77};
    flds = {8'h0a, 8'h08, 8'h09, 8'h0b};
    for (int i = 0; i < 4; i++) begin
      run(hdrs[31-8*i -: 8], ops[31-8*i -: 8], 0, i == 0, flds[31-8*i -: 8], 0);
    end
  endtask

  // Own id, id within the base range, foreign id
  task automatic t_radio();
    run(8'h6b, 8'h55, {32'h1, UID, 8'h0}, 0, 8'h58, 0);
    cmp({radio_tx_tel[55:48], radio_tx_tel[79:72], radio_tx_tel[7:0]}, 24'h01_676b);
    run(8'h6b, 8'h55, {32'h1, 32'hffff_fb05, 8'h0}, 0, 8'h58, 0);
    run(8'h6b, 8'h55, {32'h1, 32'h1234_5600, 8'h0}, 0, 8'h22, 0);
    cmp(gos, 2);
  endtask

  // Silent reset command; a slow host still gets the version
  task automatic t_misc();
    host.send(CMD, 8'h0a, 0, 0);
    repeat (40) @(negedge sys_clk);
    cmp(host.n, 0);
    cmp(resets, 1);
    host.slow = 1;
    run(CMD, 8'h4b, 0, 0, 8'h8c, {VER, 8'h0});
    host.slow = 0;
    cmp(lates, 0);
    // Stalled host holds the first byte past the deadline: one late flag
    host.slow = 2;
    host.send(CMD, 8'h4b, 0, 0);
    repeat (60) @(negedge sys_clk);
    host.slow = 0;
    answer(8'h8c, {VER, 8'h0});
    cmp(lates, 1);
  endtask

  task automatic conclude();
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    repeat (10) @(negedge sys_clk);
    rst_b = 1'b1;
    t_sens();
    t_base();
    t_syntax();
    t_radio();
    t_misc();
    conclude();
  end

  // Watchdog, about ten times the expected run
  initial begin
    #200000;
    errors++;
    conclude();
  end
endmodule
`default_nettype wire

// [testbench/sct_host.sv]
`default_nettype none
module sct_host (
  // Clock
  input wire logic        sys_clk,
  // Bytes toward the handler
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  // Bytes from the handler
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_byte,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] resp [0:13];
  int         n    = 0;
  int         slow = 0;
  int         cyc  = 0;

  // Link idle at start
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'hff;
  end

  // Whole telegram, one byte a cycle; bad flips checksum bits
  task automatic send(input logic [7:0] hdr, op, input logic [71:0] d, input logic [7:0] bad);
    logic [7:0]   sum;
    logic [111:0] t;
    sum = hdr + op;
    for (int i = 0; i < 9; i++) begin
      sum = sum + d[71-8*i -: 8];
    end
    t = {8'ha5, 8'h5a, hdr, op, d, sum ^ bad};
    n = 0;
    for (int i = 0; i < 14; i++) begin
      @(negedge sys_clk);
      rx_valid = 1'b1;
      rx_byte = t[111-8*i -: 8];
    end
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_byte = ~rx_byte; // No stale byte left on a released line
  endtask

  // Slow mode 1 takes one byte in three cycles, mode 2 stalls
  always @(negedge sys_clk) begin
    cyc <= cyc + 1;
    tx_ready <= (slow == 0) || (slow == 1 && cyc % 3 == 0);
  end

  // Collect the answer
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready && n < 14) begin
      resp[n] <= tx_byte;
      n <= n + 1;
    end
  end
endmodule
`default_nettype wire
